// ---- src/bpo_pkg.sv ----
// Package for the dual bidirectional port with peripheral overrides.
// Assumes an 8-bit register port and one system clock.
package bpo_pkg;

  ////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port
  localparam logic [3:0] BPO_OFS_H_DIR   = 4'h0;
  localparam logic [3:0] BPO_OFS_H_PINS  = 4'h1;
  localparam logic [3:0] BPO_OFS_H_LATCH = 4'h2;
  localparam logic [3:0] BPO_OFS_J_DIR   = 4'h3;
  localparam logic [3:0] BPO_OFS_J_PINS  = 4'h4;
  localparam logic [3:0] BPO_OFS_J_LATCH = 4'h5;
  localparam logic [3:0] BPO_OFS_MEMCTL  = 4'h6;
  localparam logic [3:0] BPO_OFS_PWMTRI  = 4'h7;
  localparam logic [3:0] BPO_OFS_ANASEL  = 4'h8;

  ////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int         BPO_EXTERNAL_BUS_DISABLE_BIT    = 7;
  localparam int         BPO_PWM_LSB      = 4;
  localparam logic [7:0] BPO_DIR_RST      = 8'hff;
  localparam logic [7:0] BPO_LATCH_RST    = 8'h00;
  localparam logic       BPO_EXTERNAL_BUS_DISABLE_RST    = 1'b1;
  localparam logic [3:0] BPO_PWMTRI_RST   = 4'h0;
  localparam logic [3:0] BPO_ANASEL_RST   = 4'hf;
  localparam int         BPO_SYNC_STAGES  = 3;

  ////////////////////////////////////////////////////////////////////
  // Memory-interface control strobes, one per pin of port J
  typedef struct packed {
    logic upper_byte_enable;
    logic lower_byte_enable;
    logic chip_enable;
    logic byte_address_bit;
    logic write_high_strobe;
    logic write_low_strobe;
    logic output_enable;
    logic address_latch;
  } bpo_emi_ctrl_t;

  // PWM sources on port H pins 4..7, index 0 is pin 4
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] active;
    logic [3:0] shutdown;
  } bpo_pwm_t;

endpackage : bpo_pkg

// ---- src/bpo_port.sv ----
// Two 8-bit bidirectional ports with PWM, analog and memory-bus overrides.
// Assumes a single-master register port and pads resolved outside.
//
// Overview of operation
// (R1) Direction bit one tri-states the pin
// (R2) Direction bit zero drives the output latch
// (R3) Eight pins per port, independent directions
// (R4) Latch read-modify-write sees latch, not pins
// (R5) Port J pins are inputs after reset
// (R6) Pins read returns levels, write sets latch
// (R7) Latch read returns latch, write sets latch
// (R8) Memory bus drives all port J pins
// (R9) Clearing bus-disable bit seven starts takeover
// (R10) Port H pins 4-7 reset as analog
// (R11) Active PWM overrides latch when direction zero
// (R12) PWM output may tri-state on shutdown
// (R13) PWM mapping on port H pins 4-7
// (R14) One memory control strobe per J pin
// (R15) Direction registers reset to all ones
// (R16) Priority: memory bus, PWM, then latch
`timescale 1ns/100ps
module bpo_port
  import bpo_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  input  wire logic [3:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire logic          reg_write_in,
  input  wire logic          reg_read_in,
  output logic      [7:0]    reg_rdata_out,
  input  wire logic [7:0]    port_h_pin_in,
  output logic      [7:0]    port_h_pin_out,
  output logic      [7:0]    port_h_pin_oe_out,
  input  wire logic [7:0]    port_j_pin_in,
  output logic      [7:0]    port_j_pin_out,
  output logic      [7:0]    port_j_pin_oe_out,
  input  wire bpo_pwm_t      pwm_in,
  input  wire bpo_emi_ctrl_t emi_ctrl_in,
  output logic               ext_bus_enabled_out,
  output logic      [3:0]    analog_enable_out
);

  ////////////////////////////////////////////////////////////////////
  // Drive of a plain port bit: returns {oe, level}
  function automatic logic [1:0] bpo_drive(input logic dir,
                                           input logic lat);
    bpo_drive = {~dir, lat};                          // [R1] [R2]
  endfunction : bpo_drive

  function automatic logic bpo_hit(input logic [3:0] a,
                                   input logic [3:0] ofs);
    bpo_hit = (a == ofs);
  endfunction : bpo_hit

  ////////////////////////////////////////////////////////////////////
  // Synchronised pin levels, H in the low byte
  logic [15:0] pins_sync;

  bpo_sync #(
    .WIDTH (16)
  ) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .d_in     ({port_j_pin_in, port_h_pin_in}),
    .q_out    (pins_sync)
  );

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] dir_h_q,  dir_h_d;
  logic [7:0] lat_h_q,  lat_h_d;
  logic [7:0] dir_j_q,  dir_j_d;
  logic [7:0] lat_j_q,  lat_j_d;
  logic       external_bus_disable_q,  external_bus_disable_d;
  logic [3:0] pwmtri_q, pwmtri_d;
  logic [3:0] anasel_q, anasel_d;
  logic [7:0] rdata_d;
  logic [7:0] pins_h_rd;
  logic [7:0] pins_j_rd;
  logic [3:0] ana_en;

  // Analog needs the direction bit set too
  assign ana_en    = anasel_q & dir_h_q[7:BPO_PWM_LSB];         // [R10]
  // Analog-selected pins read as zero in the digital path
  assign pins_h_rd = pins_sync[7:0] & ~{ana_en, 4'h0};
  assign pins_j_rd = pins_sync[15:8];

  always_comb begin
    dir_h_d  = dir_h_q;
    lat_h_d  = lat_h_q;
    dir_j_d  = dir_j_q;
    lat_j_d  = lat_j_q;
    external_bus_disable_d  = external_bus_disable_q;
    pwmtri_d = pwmtri_q;
    anasel_d = anasel_q;
    if (reg_write_in) begin
      unique case (reg_addr_in)
        BPO_OFS_H_DIR:   dir_h_d = reg_wdata_in;                 // [R3]
        BPO_OFS_H_PINS:  lat_h_d = reg_wdata_in;                 // [R6]
        BPO_OFS_H_LATCH: lat_h_d = reg_wdata_in;                 // [R7]
        BPO_OFS_J_DIR:   dir_j_d = reg_wdata_in;                 // [R3]
        BPO_OFS_J_PINS:  lat_j_d = reg_wdata_in;                 // [R6]
        BPO_OFS_J_LATCH: lat_j_d = reg_wdata_in;                 // [R7]
        BPO_OFS_MEMCTL:  external_bus_disable_d = reg_wdata_in[BPO_EXTERNAL_BUS_DISABLE_BIT];  // [R9]
        BPO_OFS_PWMTRI:  pwmtri_d = reg_wdata_in[3:0];           // [R12]
        BPO_OFS_ANASEL:  anasel_d = reg_wdata_in[3:0];           // [R10]
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_read_in) begin
      unique case (reg_addr_in)
        BPO_OFS_H_DIR:   rdata_d = dir_h_q;
        BPO_OFS_H_PINS:  rdata_d = pins_h_rd;                    // [R6]
        BPO_OFS_H_LATCH: rdata_d = lat_h_q;                      // [R4] [R7]
        BPO_OFS_J_DIR:   rdata_d = dir_j_q;
        BPO_OFS_J_PINS:  rdata_d = pins_j_rd;                    // [R6]
        BPO_OFS_J_LATCH: rdata_d = lat_j_q;                      // [R4] [R7]
        BPO_OFS_MEMCTL:  rdata_d = {external_bus_disable_q, 7'h00};
        BPO_OFS_PWMTRI:  rdata_d = {4'h0, pwmtri_q};
        BPO_OFS_ANASEL:  rdata_d = {4'h0, anasel_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dir_h_q       <= BPO_DIR_RST;                              // [R15]
      lat_h_q       <= BPO_LATCH_RST;
      dir_j_q       <= BPO_DIR_RST;                              // [R5] [R15]
      lat_j_q       <= BPO_LATCH_RST;
      external_bus_disable_q       <= BPO_EXTERNAL_BUS_DISABLE_RST;                            // [R5]
      pwmtri_q      <= BPO_PWMTRI_RST;
      anasel_q      <= BPO_ANASEL_RST;                           // [R10]
      reg_rdata_out <= 8'h00;
    end else begin
      dir_h_q       <= dir_h_d;
      lat_h_q       <= lat_h_d;
      dir_j_q       <= dir_j_d;
      lat_j_q       <= lat_j_d;
      external_bus_disable_q       <= external_bus_disable_d;
      pwmtri_q      <= pwmtri_d;
      anasel_q      <= anasel_d;
      reg_rdata_out <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drive; registered so outputs come from flip-flops, at the
  // cost of one cycle from register change to pin
  logic [7:0] h_out_d, h_oe_d;
  logic [7:0] j_out_d, j_oe_d;
  logic       ebus_en_d;
  logic [1:0] drv;
  logic [7:0] emi_bits;

  assign emi_bits  = emi_ctrl_in;                                // [R14]
  assign ebus_en_d = ~external_bus_disable_q;                                   // [R9]

  always_comb begin
    h_out_d = 8'h00;
    h_oe_d  = 8'h00;
    j_out_d = 8'h00;
    j_oe_d  = 8'h00;
    drv     = 2'b00;
    for (int i = 0; i < 8; i++) begin
      drv        = bpo_drive(dir_h_q[i], lat_h_q[i]);            // [R1] [R2]
      h_oe_d[i]  = drv[1];
      h_out_d[i] = drv[0];
      drv = bpo_drive(dir_j_q[i], lat_j_q[i]);                   // [R1] [R2]
      if (ebus_en_d) begin
        j_oe_d[i]  = 1'b1;                                       // [R8] [R16]
        j_out_d[i] = emi_bits[i];                                // [R14]
      end else begin
        j_oe_d[i]  = drv[1];
        j_out_d[i] = drv[0];
      end
    end
    // Separate loop keeps every PWM index in range
    // Pin 4: pwm3 C, 5: pwm3 B, 6: pwm1 C, 7: pwm1 B
    for (int k = 0; k < 4; k++) begin
      if (pwm_in.active[k] && !dir_h_q[k+BPO_PWM_LSB]) begin     // [R11] [R13] [R16]
        h_out_d[k+BPO_PWM_LSB] = pwm_in.level[k];
        h_oe_d[k+BPO_PWM_LSB]  = ~(pwm_in.shutdown[k] & pwmtri_q[k]); // [R12]
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      port_h_pin_out      <= 8'h00;
      port_h_pin_oe_out   <= 8'h00;
      port_j_pin_out      <= 8'h00;
      port_j_pin_oe_out   <= 8'h00;
      ext_bus_enabled_out <= 1'b0;
      analog_enable_out   <= 4'h0;
    end else begin
      port_h_pin_out      <= h_out_d;
      port_h_pin_oe_out   <= h_oe_d;
      port_j_pin_out      <= j_out_d;
      port_j_pin_oe_out   <= j_oe_d;
      ext_bus_enabled_out <= ebus_en_d;
      analog_enable_out   <= ana_en;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_wr(logic [3:0] ofs);
    reg_write_in && reg_addr_in == ofs;
  endsequence

  sequence s_rd(logic [3:0] ofs);
    reg_read_in && reg_addr_in == ofs;
  endsequence

  AST_J_INPUT_TRISTATE: // [R1]
    assert property (external_bus_disable_q && $stable(external_bus_disable_q) && dir_j_q[0]
                     |=> !port_j_pin_oe_out[0])
    else $error("direction one did not tri-state port J pin");

  AST_H_LOW_DRIVES_LATCH: // [R2]
    assert property (1'b1 |=> port_h_pin_out[3:0] == $past(lat_h_q[3:0])
                     && port_h_pin_oe_out[3:0] == ~$past(dir_h_q[3:0]))
    else $error("port H low pins do not follow latch and direction");

  AST_H_DIR_PER_BIT: // [R3]
    assert property (s_wr(BPO_OFS_H_DIR) |=> ##1
                     port_h_pin_oe_out[3:0] == ~$past(reg_wdata_in[3:0], 2))
    else $error("port H direction write not reflected per pin");

  AST_LATCH_RMW: // [R4]
    assert property (s_wr(BPO_OFS_J_PINS) ##1 s_rd(BPO_OFS_J_LATCH)
                     |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("latch read after pins write lost the value");

  AST_J_IDLE_INPUTS: // [R5]
    assert property (external_bus_disable_q && dir_j_q == BPO_DIR_RST
                     ##1 external_bus_disable_q && dir_j_q == BPO_DIR_RST
                     |=> port_j_pin_oe_out == 8'h00)
    else $error("port J drives with all directions set");

  AST_PINS_READ: // [R6]
    assert property (s_rd(BPO_OFS_J_PINS) |=> reg_rdata_out == $past(pins_j_rd))
    else $error("pins read did not return pin levels");

  AST_LATCH_WRITE: // [R7]
    assert property (s_wr(BPO_OFS_H_LATCH) |=> lat_h_q == $past(reg_wdata_in))
    else $error("latch write not stored");

  AST_EMI_OWNS_J: // [R8]
    assert property (!external_bus_disable_q |=> port_j_pin_oe_out == 8'hff
                     && port_j_pin_out == $past(emi_bits))
    else $error("memory bus does not own port J");

  AST_EXTERNAL_BUS_DISABLE_TAKEOVER: // [R9]
    assert property (s_wr(BPO_OFS_MEMCTL) && !reg_wdata_in[BPO_EXTERNAL_BUS_DISABLE_BIT]
                     |=> ##1 ext_bus_enabled_out && port_j_pin_oe_out == 8'hff)
    else $error("clearing bus disable did not start takeover");

  AST_ANALOG_ENABLE: // [R10]
    assert property (1'b1 |=> analog_enable_out
                     == $past(anasel_q & dir_h_q[7:4]))
    else $error("analog enable does not track select and direction");

  for (genvar k = 0; k < 4; k++) begin : g_pwm_chk
    AST_PWM_OVERRIDE: // [R11]
      assert property (pwm_in.active[k] && !dir_h_q[k+4]
                       && !pwm_in.shutdown[k]
                       |=> port_h_pin_oe_out[k+4]
                       && port_h_pin_out[k+4] == $past(pwm_in.level[k]))
      else $error("active PWM did not override latch");

    AST_PWM_SHUTDOWN: // [R12]
      assert property (pwm_in.active[k] && !dir_h_q[k+4]
                       && pwm_in.shutdown[k] && pwmtri_q[k]
                       |=> !port_h_pin_oe_out[k+4])
      else $error("PWM shutdown did not tri-state pin");

    AST_PWM_PRIORITY: // [R16]
      assert property (!pwm_in.active[k] |=>
                       port_h_pin_out[k+4] == $past(lat_h_q[k+4]))
      else $error("inactive PWM pin does not show latch");
  end

  AST_J_NO_EMI_LATCH: // [R16]
    assert property (external_bus_disable_q |=> port_j_pin_out == $past(lat_j_q)
                     && port_j_pin_oe_out == ~$past(dir_j_q))
    else $error("port J without bus does not follow latch");

endmodule : bpo_port

// ---- src/bpo_sync.sv ----
// Pin input synchroniser with a two-sample agreement filter.
// Assumes asynchronous pin levels; output is in the clock_in domain.
`timescale 1ns/100ps
module bpo_sync
  import bpo_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] q_d;

  // Only bits where the last two samples agree may change
  always_comb begin
    q_d = (q_out & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      q_out <= '0;
    end else begin
      s1_q  <= d_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      q_out <= q_d;
    end
  end

endmodule : bpo_sync

// ---- verif/bpo_board.sv ----
// Board-side pad model for one 8-bit port.
// Assumes the device output enable is high while the device drives the pad.
`timescale 1ns/100ps
module bpo_board (
  input  wire logic       clock_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic [7:0] ext_in,
  output logic      [7:0] pad_out
);
  logic [7:0] float_q = 8'h55;

  // Undriven pads wander each cycle so a stale level never reads as good
  always @(posedge clock_in) float_q <= ~float_q;

  assign pad_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in)
                 | (~oe_in & ~ext_en_in & float_q);
endmodule : bpo_board

// ---- verif/bpo_port_tb.sv ----
// Self-checking bench for the dual port block.
// Assumes one board model per port closing the pads.
`timescale 1ns/100ps
module bpo_port_tb;
  import bpo_pkg::*;
  typedef struct packed {
    logic [2:0] k;
    logic [7:0] v;
    logic [7:0] m;
  } bpo_note_t;
  logic          clock_in = 1'b0;
  logic          rst_in   = 1'b1;
  logic [3:0]    addr     = 4'h0;
  logic [7:0]    wdata    = 8'h00;
  logic          wr       = 1'b0;
  logic          rd       = 1'b0;
  logic          rd_d     = 1'b0;
  logic          look     = 1'b0;
  logic [7:0]    h_ext    = 8'h00;
  logic [7:0]    j_ext    = 8'h00;
  bpo_pwm_t      pwm      = '0;
  bpo_emi_ctrl_t emi      = '0;
  logic [7:0]    rdata, h_pad, h_out, h_oe, j_pad, j_out, j_oe, seen, r, s;
  logic          ebus;
  logic [3:0]    ana;
  bpo_note_t     q[$];
  bpo_note_t     n;
  int            n_errors = 0;
  int            n_checks = 0;
  int            cyc      = 0;
  string         nm[7]    = '{"h_out", "h_oe", "j_out", "j_oe", "analog", "ext_bus", "rdata"};
  logic [7:0]    rst_v[10] = '{8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h80, 8'h00,
                               8'h0f, 8'h00};

  always #4 clock_in = ~clock_in;

  bpo_port dut_u (.clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .port_h_pin_in(h_pad), .port_h_pin_out(h_out), .port_h_pin_oe_out(h_oe),
    .port_j_pin_in(j_pad), .port_j_pin_out(j_out), .port_j_pin_oe_out(j_oe),
    .pwm_in(pwm), .emi_ctrl_in(emi), .ext_bus_enabled_out(ebus), .analog_enable_out(ana));
  bpo_board h_brd (.clock_in(clock_in), .oe_in(h_oe), .drv_in(h_out), .ext_en_in(8'hff),
    .ext_in(h_ext), .pad_out(h_pad));
  bpo_board j_brd (.clock_in(clock_in), .oe_in(j_oe), .drv_in(j_out), .ext_en_in(8'hff),
    .ext_in(j_ext), .pad_out(j_pad));

  ////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    look  <= 1'b0;
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_in);
    look <= 1'b0;
    addr <= a;
    rd   <= 1'b1;
    q.push_back('{3'd6, e, 8'hff});
    @(posedge clock_in);
    rd <= 1'b0;
  endtask : rd_reg

  // Write followed by a read with no gap between the strobes
  task automatic wr_rd(input logic [3:0] wa, input logic [7:0] d,
                       input logic [3:0] ra, input logic [7:0] e);
    @(posedge clock_in);
    look  <= 1'b0;
    addr  <= wa;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_in);
    wr    <= 1'b0;
    addr  <= ra;
    rd    <= 1'b1;
    q.push_back('{3'd6, e, 8'hff});
    @(posedge clock_in);
    rd    <= 1'b0;
  endtask : wr_rd

  // Pin notes are taken one edge later, when registered outputs have landed
  task automatic chk(input logic [2:0] k, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock_in);
    q.push_back('{k, e & m, m});
    look <= 1'b1;
  endtask : chk

  task automatic settle;
    @(posedge clock_in);
    look <= 1'b0;
    repeat (8) @(posedge clock_in);
  endtask : settle

  ////////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    rd_d <= rd;
    cyc  <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end else if (rd_d || look) begin
      n_checks++;
      if (q.size() == 0) n = '{3'd6, ~rdata, 8'hff};
      else n = q.pop_front();
      case (n.k)
        3'd0:    seen = h_out;
        3'd1:    seen = h_oe;
        3'd2:    seen = j_out;
        3'd3:    seen = j_oe;
        3'd4:    seen = {4'h0, ana};
        3'd5:    seen = {7'h00, ebus};
        default: seen = rdata;
      endcase
      if ((seen & n.m) !== n.v) begin
        n_errors++;
        $display("FAIL %s expected %h seen %h", nm[n.k], n.v, seen & n.m);
      end
    end
  end

  initial begin
    void'($urandom(32'h6a6a));
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 10; i++) rd_reg(4'(i), rst_v[i]);
    settle();
    chk(3'd1, 8'h00, 8'hff);
    chk(3'd3, 8'h00, 8'hff);
    chk(3'd4, 8'h0f, 8'hff);
    chk(3'd5, 8'h00, 8'hff);
    r = 8'($urandom());
    s = 8'($urandom());
    wr_reg(BPO_OFS_H_PINS, r);
    wr_reg(BPO_OFS_J_LATCH, s);
    wr_reg(4'h9, 8'h5a);
    rd_reg(BPO_OFS_H_LATCH, r);
    rd_reg(BPO_OFS_J_LATCH, s);
    rd_reg(4'h9, 8'h00);
    r = 8'($urandom());
    wr_reg(BPO_OFS_J_DIR, r);
    settle();
    chk(3'd3, ~r, 8'hff);
    chk(3'd2, s, ~r);
    wr_reg(BPO_OFS_J_DIR, 8'hff);
    j_ext <= 8'($urandom());
    h_ext <= 8'($urandom());
    settle();
    rd_reg(BPO_OFS_J_PINS, j_ext);
    rd_reg(BPO_OFS_J_LATCH, s);
    s = 8'($urandom());
    wr_rd(BPO_OFS_J_PINS, s, BPO_OFS_J_LATCH, s);
    rd_reg(BPO_OFS_J_PINS, j_ext);
    rd_reg(BPO_OFS_H_PINS, {4'h0, h_ext[3:0]});
    wr_reg(BPO_OFS_ANASEL, 8'h00);
    settle();
    rd_reg(BPO_OFS_H_PINS, h_ext);
    chk(3'd4, 8'h00, 8'hff);
    // Level 2 on active 4'ha lets a swapped pin mapping show up
    wr_reg(BPO_OFS_H_LATCH, 8'h50);
    wr_reg(BPO_OFS_H_DIR, 8'h0f);
    pwm <= {4'h2, 4'ha, 4'h0};
    settle();
    chk(3'd0, 8'h70, 8'hf0);
    chk(3'd1, 8'hf0, 8'hf0);
    wr_reg(BPO_OFS_PWMTRI, 8'h02);
    pwm <= {4'h2, 4'ha, 4'hf};
    settle();
    chk(3'd1, 8'hd0, 8'hf0);
    wr_reg(BPO_OFS_H_DIR, 8'hff);
    settle();
    chk(3'd1, 8'h00, 8'hf0);
    r = 8'($urandom());
    emi <= r;
    wr_reg(BPO_OFS_MEMCTL, 8'h00);
    settle();
    chk(3'd5, 8'h01, 8'hff);
    chk(3'd3, 8'hff, 8'hff);
    chk(3'd2, r, 8'hff);
    wr_reg(BPO_OFS_MEMCTL, 8'h80);
    settle();
    chk(3'd5, 8'h00, 8'hff);
    chk(3'd3, 8'h00, 8'hff);
    settle();
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_reg(BPO_OFS_J_DIR, 8'hff);
    rd_reg(BPO_OFS_H_LATCH, 8'h00);
    settle();
    chk(3'd3, 8'h00, 8'hff);
    settle();
    end_sim();
  end
endmodule : bpo_port_tb
